/* hdl/uda_pkg.sv */
/*
 * shared types and constants of the low-power data acquisition block:
 * widths, source and state encodings, the configuration carrier.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package uda_pkg;

    localparam int ADC_W   = 12;                    // converter sample width
    localparam int PC_W    = 16;                    // pulse count width, saturating
    localparam int DAT_W   = 20;                    // sample/sum width: 16 x 16 bits fits
    localparam int WIN_W   = 10;                    // window length field, value minus one
    localparam int NUM_W   = 4;                     // 1..16 fields, value minus one
    localparam int FIFO_N  = 16;                    // physical fifo entries
    localparam int PTR_W   = 4;                     // fifo index width
    localparam int LVL_W   = 5;                     // fifo level width, 0..16
    localparam int XC_W    = 8;                     // crossing streak width
    localparam int BL_W    = 8;                     // burst length field, value minus one
    localparam int BD_W    = 16;                    // burst gap in system clocks
    localparam int GPIO_N  = 4;                     // selectable pulse inputs

    localparam logic [DAT_W-1:0] SUM_RST  = 20'h00000;   // accumulator reset value
    localparam logic [PC_W-1:0]  PC_MAX   = 16'hFFFF;    // pulse count saturation
    localparam logic [XC_W-1:0]  XC_MAX   = 8'hFF;       // streak saturation
    localparam logic [LVL_W-1:0] LVL_ONE  = 5'h01;       // depth = field + 1

    // sample source choice
    typedef enum logic {
        UDA_SRC_ADC = 1'b0,
        UDA_SRC_PC  = 1'b1
    } uda_src_t;

    // burst sequencer states, gray along idle -> burst -> gap
    typedef enum logic [1:0] {
        UDA_ST_IDLE  = 2'b00,
        UDA_ST_BURST = 2'b01,
        UDA_ST_GAP   = 2'b11
    } uda_state_t;

    // static configuration carried as one bundle
    typedef struct packed {
        uda_src_t               src_sel;            // sample source
        logic [1:0]             gpio_sel;           // pulse input select
        logic [WIN_W-1:0]       window_len;         // 32 kHz periods minus one
        logic                   accumulate_enable;  // sum samples before storing
        logic [NUM_W-1:0]       acc_count;          // samples per sum minus one
        logic                   thr_hi_en;          // above-limit check on
        logic                   thr_lo_en;          // below-limit check on
        logic [DAT_W-1:0]       thr_hi;             // upper limit
        logic [DAT_W-1:0]       thr_lo;             // lower limit
        logic [XC_W-1:0]        cross_count;        // streak needed for wake
        logic [NUM_W-1:0]       fifo_depth;         // usable entries minus one
        logic                   burst_en;           // burst sampling mode
        logic [BL_W-1:0]        burst_len;          // samples per burst minus one
        logic [BD_W-1:0]        burst_gap;          // clocks between bursts
    } uda_cfg_t;

endpackage : uda_pkg

/* hdl/uda_skid_buf.sv */
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes one clock, both sides synchronous to it.
 */
`timescale 1ns/1ps
module uda_skid_buf #(
    parameter int W = 20
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    import uda_pkg::*;

    logic [W-1:0] head_reg, head_next;              // oldest word
    logic [W-1:0] tail_reg, tail_next;              // second word
    logic [1:0]   cnt_reg,  cnt_next;               // words held
    logic         push, pop;

    assign in_ready_o  = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o  = head_reg;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // next contents
    always_comb begin
        head_next = head_reg;
        tail_next = tail_reg;
        cnt_next  = cnt_reg;
        case ({push, pop})
            2'b10: begin                            // fill only
                if (cnt_reg == 2'h0) head_next = in_data_i;
                else tail_next = in_data_i;
                cnt_next = cnt_reg + 2'h1;
            end
            2'b01: begin                            // drain only
                head_next = tail_reg;
                cnt_next  = cnt_reg - 2'h1;
            end
            2'b11: begin                            // both, count holds
                if (cnt_reg == 2'h1) head_next = in_data_i;
                else begin
                    head_next = tail_reg;
                    tail_next = in_data_i;
                end
            end
            default: ;
        endcase
    end

    // register stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            head_reg <= '0;
            tail_reg <= '0;
            cnt_reg  <= 2'h0;
        end else begin
            head_reg <= head_next;
            tail_reg <= tail_next;
            cnt_reg  <= cnt_next;
        end
    end

    // never more than two words held
    skid_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cnt_reg <= 2'h2) else $error("skid buffer overflow");

endmodule : uda_skid_buf

/* hdl/uda_pulse_counter.sv */
/*
 * pulse counter: counts rising edges of one of four pins over a window
 * of 32 kHz periods. pins and the slow clock are asynchronous and are
 * synchronised here. assumes clk_i is far faster than both.
 */
`timescale 1ns/1ps
module uda_pulse_counter (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    // pins
    input  wire logic [uda_pkg::GPIO_N-1:0]   gpio_i,
    input  wire logic                         clk32k_i,
    // setup
    input  wire logic [1:0]                   gpio_sel_i,
    input  wire logic [uda_pkg::WIN_W-1:0]    window_len_i,
    // result handshake
    output logic                              cnt_valid_o,
    input  wire logic                         cnt_ready_i,
    output logic [uda_pkg::PC_W-1:0]          cnt_data_o
);
    import uda_pkg::*;

    logic [GPIO_N:0]  sync1_reg, sync2_reg;         // pins + slow clock, two stages
    logic             pin_d_reg, tick_d_reg;        // edge history
    logic             pin_s, tick_s, pin_rise, tick;
    logic [WIN_W-1:0] win_reg,   win_next;          // periods elapsed
    logic [PC_W-1:0]  cnt_reg,   cnt_next;          // edges this window
    logic [PC_W-1:0]  res_reg,   res_next;          // held result
    logic             vld_reg,   vld_next;          // result waiting
    logic             win_end;

    assign pin_s    = sync2_reg[gpio_sel_i];
    assign tick_s   = sync2_reg[GPIO_N];
    assign pin_rise = pin_s & ~pin_d_reg;
    assign tick     = tick_s & ~tick_d_reg;
    assign win_end  = tick & (win_reg == window_len_i);

    assign cnt_valid_o = vld_reg;
    assign cnt_data_o  = res_reg;

    // window and count bookkeeping
    always_comb begin
        win_next = win_reg;
        cnt_next = cnt_reg;
        res_next = res_reg;
        vld_next = vld_reg & ~cnt_ready_i;
        if (pin_rise && cnt_reg != PC_MAX) cnt_next = cnt_reg + 1'b1;
        if (win_end) begin
            win_next = '0;
            res_next = cnt_next;                    // newer window replaces unread one
            vld_next = 1'b1;
            cnt_next = '0;
        end else if (tick) begin
            win_next = win_reg + 1'b1;
        end
    end

    // synchronisers and state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            pin_d_reg  <= 1'b0;
            tick_d_reg <= 1'b0;
            win_reg    <= '0;
            cnt_reg    <= '0;
            res_reg    <= '0;
            vld_reg    <= 1'b0;
        end else begin
            sync1_reg  <= {clk32k_i, gpio_i};
            sync2_reg  <= sync1_reg;
            pin_d_reg  <= pin_s;
            tick_d_reg <= tick_s;
            win_reg    <= win_next;
            cnt_reg    <= cnt_next;
            res_reg    <= res_next;
            vld_reg    <= vld_next;
        end
    end

    // a result appears only at the close of a full window
    window_close_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(vld_reg) |-> $past(tick) && $past(win_reg) == $past(window_len_i))
        else $error("pulse count reported outside window end");

endmodule : uda_pulse_counter

/* hdl/uda_top.sv */
/*
 * low-power data acquisition: source select, accumulator, threshold
 * streak detector, burst sequencer, sample fifo and wake requests.
 * assumes configuration is held steady while sampling and that the
 * converter holds a sample until it is taken.
 */
// What this block does
// - pulse counter input picks one of four pins
// - count pulses per 1..1024 slow-clock window
// - sum 1 to 16 consecutive samples
// - summing only when accumulate enable set
// - each finished sum becomes one fifo entry
// - separate upper and lower limit checks
// - wake after programmed streak of crossings
// - fifo usable depth programmable 1 to 16
// - burst of samples then programmable gap
// - threshold and fifo-full wake causes
// - source selectable: pulse counter or converter
`timescale 1ns/1ps
module uda_top (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    // configuration
    input  wire uda_pkg::uda_cfg_t            cfg_i,
    // pulse counter pins
    input  wire logic [uda_pkg::GPIO_N-1:0]   gpio_i,
    input  wire logic                         clk32k_i,
    // converter samples
    output logic                              adc_req_o,
    input  wire logic                         adc_valid_i,
    output logic                              adc_ready_o,
    input  wire logic [uda_pkg::ADC_W-1:0]    adc_data_i,
    // fifo read side
    output logic                              rd_valid_o,
    input  wire logic                         rd_ready_i,
    output logic [uda_pkg::DAT_W-1:0]         rd_data_o,
    output logic [uda_pkg::LVL_W-1:0]         fifo_level_o,
    // wake requests
    input  wire logic [1:0]                   wake_clr_i,
    output logic                              wake_thr_o,
    output logic                              wake_fifo_o,
    output logic                              fifo_full_o
);
    import uda_pkg::*;

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // ---- source selection
    logic             pc_valid, pc_ready;           // pulse counter handshake
    logic [PC_W-1:0]  pc_data;                      // pulse count
    logic             src_valid, take;              // a sample is accepted
    logic [DAT_W-1:0] sample;                       // widened sample
    logic             acc_ready;                    // accumulator can take
    logic             adc_take;                     // converter word consumed

    uda_pulse_counter u_pc (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .gpio_i       (gpio_i),
        .clk32k_i     (clk32k_i),
        .gpio_sel_i   (cfg_i.gpio_sel),
        .window_len_i (cfg_i.window_len),
        .cnt_valid_o  (pc_valid),
        .cnt_ready_i  (pc_ready),
        .cnt_data_o   (pc_data)
    );

    // source mux, unselected source drains so it never wedges
    always_comb begin
        if (cfg_i.src_sel == UDA_SRC_PC) begin
            src_valid   = pc_valid;
            sample      = DAT_W'(pc_data);
            pc_ready    = acc_ready;
            adc_ready_o = 1'b1;
        end else begin
            src_valid   = adc_valid_i;
            sample      = DAT_W'(adc_data_i);
            pc_ready    = 1'b1;
            adc_ready_o = acc_ready;
        end
    end
    assign take     = src_valid & acc_ready;
    assign adc_take = adc_valid_i & adc_ready_o;

    // ---- accumulator
    logic [DAT_W-1:0] sum_reg, sum_next;            // running sum
    logic [NUM_W-1:0] n_reg,   n_next;              // samples summed so far
    logic [DAT_W-1:0] sum_add;                      // sum including this sample
    logic             emit;                         // result leaves this cycle
    logic             buf_ready, buf_valid;         // skid buffer handshake
    logic [DAT_W-1:0] buf_data;                     // skid buffer output

    assign acc_ready = buf_ready;
    assign sum_add   = sum_reg + sample;
    assign emit      = take & (~cfg_i.accumulate_enable | (n_reg == cfg_i.acc_count));

    // next sum and sample count
    always_comb begin
        sum_next = sum_reg;
        n_next   = n_reg;
        if (take) begin
            if (emit) begin
                sum_next = SUM_RST;
                n_next   = '0;
            end else begin
                sum_next = sum_add;
                n_next   = n_reg + 1'b1;
            end
        end
    end

    // accumulator registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum_reg <= SUM_RST;
            n_reg   <= '0;
        end else begin
            sum_reg <= sum_next;
            n_reg   <= n_next;
        end
    end

    // ---- threshold streak
    logic            hit, hit_hi;                   // sample crosses a limit, the upper one
    logic [XC_W-1:0] xc_reg,  xc_next;              // consecutive crossings
    logic            wthr_reg, wthr_next;           // threshold wake flag
    logic            dir_reg, dir_next;             // streak lies above the upper limit

    assign hit_hi = cfg_i.thr_hi_en & (sample > cfg_i.thr_hi);
    assign hit    = hit_hi | (cfg_i.thr_lo_en & (sample < cfg_i.thr_lo));

    // streak and sticky wake, set wins over clear
    always_comb begin
        xc_next   = xc_reg;
        dir_next  = dir_reg;
        wthr_next = wthr_reg & ~wake_clr_i[0];
        if (take) begin
            dir_next = hit_hi;
            if (!hit) xc_next = '0;
            else if (hit_hi != dir_reg) xc_next = XC_W'(1'b1); // side changed, new streak
            else if (xc_reg != XC_MAX) xc_next = xc_reg + 1'b1;
            if (hit && xc_next >= cfg_i.cross_count && cfg_i.cross_count != '0)
                wthr_next = 1'b1;
        end
    end

    // streak registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xc_reg   <= '0;
            wthr_reg <= 1'b0;
            dir_reg  <= 1'b0;
        end else begin
            xc_reg   <= xc_next;
            wthr_reg <= wthr_next;
            dir_reg  <= dir_next;
        end
    end
    assign wake_thr_o = wthr_reg;

    // ---- buffer between accumulator and fifo
    logic fifo_wr, fifo_rd;                         // fifo strobes
    logic fifo_has_room;                            // level below depth

    uda_skid_buf #(.W(DAT_W)) u_buf (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (emit),
        .in_ready_o  (buf_ready),
        .in_data_i   (cfg_i.accumulate_enable ? sum_add : sample),
        .out_valid_o (buf_valid),
        .out_ready_i (fifo_has_room),
        .out_data_o  (buf_data)
    );

    // ---- sample fifo
    logic [DAT_W-1:0] mem_reg  [FIFO_N];            // storage
    logic [DAT_W-1:0] mem_next [FIFO_N];
    logic [PTR_W-1:0] wp_reg, wp_next;              // write index
    logic [PTR_W-1:0] rp_reg, rp_next;              // read index
    logic [LVL_W-1:0] lvl_reg, lvl_next;            // stored entries
    logic [LVL_W-1:0] depth;                        // usable entries
    logic             wfifo_reg, wfifo_next;        // fifo-full wake flag

    assign depth         = LVL_W'(cfg_i.fifo_depth) + LVL_ONE;
    assign fifo_has_room = (lvl_reg < depth);
    assign fifo_wr       = buf_valid & fifo_has_room;
    assign fifo_rd       = rd_ready_i & rd_valid_o;
    assign fifo_full_o   = (lvl_reg >= depth);

    // next fifo state
    always_comb begin
        for (int i = 0; i < FIFO_N; i++) mem_next[i] = mem_reg[i];
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        lvl_next = lvl_reg;
        if (fifo_wr) begin
            mem_next[wp_reg] = buf_data;
            wp_next = (wp_reg == PTR_W'(depth - LVL_ONE)) ? '0 : wp_reg + 1'b1;
        end
        if (fifo_rd) begin
            rp_next = (rp_reg == PTR_W'(depth - LVL_ONE)) ? '0 : rp_reg + 1'b1;
        end
        case ({fifo_wr, fifo_rd})
            2'b10:   lvl_next = lvl_reg + 1'b1;
            2'b01:   lvl_next = lvl_reg - 1'b1;
            default: lvl_next = lvl_reg;
        endcase
        wfifo_next = (wfifo_reg & ~wake_clr_i[1]) | (lvl_next >= depth);
    end

    // fifo registers, storage loop per entry
    generate
        for (genvar g = 0; g < FIFO_N; g++) begin : g_mem
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) mem_reg[g] <= '0;
                else mem_reg[g] <= mem_next[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_reg    <= '0;
            rp_reg    <= '0;
            lvl_reg   <= '0;
            wfifo_reg <= 1'b0;
        end else begin
            wp_reg    <= wp_next;
            rp_reg    <= rp_next;
            lvl_reg   <= lvl_next;
            wfifo_reg <= wfifo_next;
        end
    end

    assign rd_valid_o   = (lvl_reg != '0);
    assign rd_data_o    = mem_reg[rp_reg];
    assign fifo_level_o = lvl_reg;
    assign wake_fifo_o  = wfifo_reg;

    // ---- burst sequencer
    uda_state_t      st_reg, st_next;               // sequencer state
    logic [BD_W-1:0] bc_reg, bc_next;               // burst / gap counter

    // next state, counts converter words in a burst then idles the gap
    always_comb begin
        st_next = st_reg;
        bc_next = bc_reg;
        case (st_reg)
            UDA_ST_IDLE: begin
                bc_next = '0;
                if (cfg_i.burst_en) st_next = UDA_ST_BURST;
            end
            UDA_ST_BURST: begin
                if (!cfg_i.burst_en) st_next = UDA_ST_IDLE;
                else if (adc_take) begin
                    if (bc_reg == BD_W'(cfg_i.burst_len)) begin
                        bc_next = '0;
                        st_next = (cfg_i.burst_gap == '0) ? UDA_ST_BURST : UDA_ST_GAP;
                    end else begin
                        bc_next = bc_reg + 1'b1;
                    end
                end
            end
            UDA_ST_GAP: begin
                if (!cfg_i.burst_en) st_next = UDA_ST_IDLE;
                else if (bc_reg == cfg_i.burst_gap - 1'b1) begin
                    bc_next = '0;
                    st_next = UDA_ST_BURST;
                end else begin
                    bc_next = bc_reg + 1'b1;
                end
            end
            default: begin
                st_next = UDA_ST_IDLE;
                bc_next = '0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= UDA_ST_IDLE;
            bc_reg <= '0;
        end else begin
            st_reg <= st_next;
            bc_reg <= bc_next;
        end
    end

    // continuous sampling outside burst mode
    assign adc_req_o = cfg_i.burst_en ? (st_reg == UDA_ST_BURST) : 1'b1;

    // ---- checks
    fifo_bound_a: assert property (lvl_reg <= depth)
        else $error("fifo level above programmed depth");
    full_flag_a: assert property (fifo_rd && !fifo_wr |=> !fifo_full_o)
        else $error("full kept after a read");
    full_wake_a: assert property ($rose(fifo_full_o) |-> wake_fifo_o)
        else $error("fifo full without wake request");
    streak_reset_a: assert property (take && !hit |=> xc_reg == '0)
        else $error("streak kept after a miss");
    thr_wake_a: assert property ($rose(wake_thr_o) |-> $past(take && hit))
        else $error("threshold wake without a crossing");
    acc_count_a: assert property (emit && cfg_i.accumulate_enable |=> n_reg == '0 && sum_reg == SUM_RST)
        else $error("sum not restarted after closing");
    pass_thru_a: assert property (take && !cfg_i.accumulate_enable |-> emit ##1 sum_reg == SUM_RST)
        else $error("sample not passed straight through");
    burst_gap_a: assert property (st_reg == UDA_ST_GAP |-> bc_reg < cfg_i.burst_gap)
        else $error("burst gap overran its count");

endmodule : uda_top

/* dv/uda_adc_model.sv */
/* converter model: offers queued words, valid held until taken.
   assumes a rising-edge design; this side changes on the falling edge. */
`timescale 1ns/1ps
module uda_adc_model (
    // clock and request
    input  wire logic                 clk_i,
    input  wire logic                 adc_req_i,
    // handshake
    input  wire logic                 adc_ready_i,
    output logic                      adc_valid_o = 1'b0,
    output logic [uda_pkg::ADC_W-1:0] adc_data_o = '0
);
    import uda_pkg::*;
    logic [ADC_W-1:0] word_q[$];    // words still to offer
    logic             took = 1'b0;  // taken at the last edge
    logic             slow = 1'b0;  // offer every other cycle
    logic             gap  = 1'b0;  // idle slot when slow
    // note a take from pre-edge values
    always @(posedge clk_i) took <= adc_valid_o & adc_ready_i;
    // drop a taken word, hold or offer, noise when idle
    always @(negedge clk_i) begin
        if (took) begin
            void'(word_q.pop_front());
        end
        gap = slow & ~gap;
        adc_valid_o = (adc_valid_o & ~took) | (adc_req_i & ~gap & (word_q.size() > 0));
        adc_data_o = adc_valid_o ? word_q[0] : ~adc_data_o;
    end
endmodule : uda_adc_model

/* dv/uda_top_bench.sv */
/* bench of the acquisition block: converter model, pins and slow clock,
   fifo reader checking a queue of notes. assumes design files come first. */
`timescale 1ns/1ps
module uda_top_bench;
    import uda_pkg::*;
    logic             clk_i = 1'b0, rst_b_i = 1'b0, clk32k_i = 1'b0, rd_ready_i = 1'b0, drain = 1'b0;
    uda_cfg_t         cfg_i = '0;
    logic [3:0]       gpio_i = '0;
    logic [1:0]       wake_clr_i = '0;
    logic             adc_req_o, adc_valid_i, adc_ready_o, rd_valid_o, wake_thr_o, wake_fifo_o, fifo_full_o;
    logic [ADC_W-1:0] adc_data_i, w;
    logic [DAT_W-1:0] rd_data_o, sum;
    logic [LVL_W-1:0] fifo_level_o;
    logic [DAT_W-1:0] exp_q[$];  // notes of entries, oldest first
    integer           seed = 60194;
    int               bad_count = 0, n_tests = 0, cycles = 0;
    localparam logic [ADC_W-1:0] TW[10] = '{12'h900, 12'hA00, 12'h010, 12'h900, 12'hA00,
                                           12'hFFF, 12'h500, 12'h010, 12'h020, 12'h000};
    localparam logic [9:0] TE = 10'h220;  // wake expected after samples 5 and 9
    uda_top uda_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .gpio_i(gpio_i),
        .clk32k_i(clk32k_i), .adc_req_o(adc_req_o), .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready_o),
        .adc_data_i(adc_data_i), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o),
        .fifo_level_o(fifo_level_o), .wake_clr_i(wake_clr_i), .wake_thr_o(wake_thr_o),
        .wake_fifo_o(wake_fifo_o), .fifo_full_o(fifo_full_o));
    uda_adc_model uda_adc_model_inst (.clk_i(clk_i), .adc_req_i(adc_req_o), .adc_ready_i(adc_ready_o),
        .adc_valid_o(adc_valid_i), .adc_data_o(adc_data_i));
    task automatic check_word(string what, logic [DAT_W-1:0] e, logic [DAT_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : check_word
    task automatic check_flag(string what, logic e, logic g);
        check_word(what, 20'(e), 20'(g));
    endtask : check_flag
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // reset held five cycles around a configuration change
    task automatic restart;
        rst_b_i = 1'b0;
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
    endtask : restart
    task automatic send(logic [ADC_W-1:0] v, logic keep);
        uda_adc_model_inst.word_q.push_back(v);
        if (keep) exp_q.push_back(20'(v));
    endtask : send
    task automatic wait_idle;
        while (uda_adc_model_inst.word_q.size() > 0 || exp_q.size() > 0) @(negedge clk_i);
        repeat (4) @(negedge clk_i);
    endtask : wait_idle
    task automatic pulse_clr(logic [1:0] c);
        wake_clr_i = c;
        @(negedge clk_i);
        wake_clr_i = 2'b00;
        @(negedge clk_i);
    endtask : pulse_clr
    // one slow period: n pulses on pin two, n+1 on the other pins
    task automatic slow_period(int n);
        clk32k_i = 1'b1;
        repeat (625) @(negedge clk_i);
        clk32k_i = 1'b0;
        for (int i = 0; i < 2 * n + 2; i++) begin
            gpio_i = i[0] ? 4'h0 : (i < 2 * n ? 4'hF : 4'hB);
            repeat (6) @(negedge clk_i);
        end
        repeat (600 - 12 * n) @(negedge clk_i);
    endtask : slow_period
    initial forever #12.5 clk_i = ~clk_i;
    // random reader on the fifo
    always @(negedge clk_i) rd_ready_i <= drain & 1'($random(seed));
    // watcher: every pop takes the oldest note; cycle ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
            check_word("fifo head", exp_q.size() > 0 ? exp_q.pop_front() : 'X, rd_data_o);
        end
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        // fifo of three entries fills and refuses, then drains
        cfg_i.fifo_depth = 4'h2;
        restart();
        repeat (6) send(12'($random(seed)), 1'b1);
        repeat (12) @(negedge clk_i);
        check_word("level", 20'h3, 20'(fifo_level_o));
        check_flag("full", 1'b1, fifo_full_o);
        check_flag("fifo wake", 1'b1, wake_fifo_o);
        check_flag("converter ready", 1'b0, adc_ready_o);
        drain = 1'b1;
        wait_idle();
        check_flag("full", 1'b0, fifo_full_o);
        check_flag("fifo wake", 1'b1, wake_fifo_o);
        pulse_clr(2'b10);
        check_flag("fifo wake", 1'b0, wake_fifo_o);
        // four slow converter words make one stored sum
        cfg_i = '0;
        cfg_i.accumulate_enable = 1'b1;
        cfg_i.acc_count = 4'h3;
        cfg_i.fifo_depth = 4'hF;
        restart();
        uda_adc_model_inst.slow = 1'b1;
        sum = '0;
        for (int i = 0; i < 8; i++) begin
            w = 12'($random(seed));
            send(w, 1'b0);
            sum = sum + 20'(w);
            if (i % 4 == 3) begin
                exp_q.push_back(sum);
                sum = '0;
            end
        end
        wait_idle();
        // both limits, streak of three, misses restart it, bursts of two
        uda_adc_model_inst.slow = 1'b0;
        cfg_i = '0;
        cfg_i.thr_hi_en = 1'b1;
        cfg_i.thr_lo_en = 1'b1;
        cfg_i.thr_hi = 20'h00800;
        cfg_i.thr_lo = 20'h00100;
        cfg_i.cross_count = 8'h03;
        cfg_i.burst_en = 1'b1;
        cfg_i.burst_len = 8'h01;
        cfg_i.burst_gap = 16'h0100;
        cfg_i.fifo_depth = 4'hF;
        restart();
        for (int i = 0; i < 10; i++) begin
            if (i == 6) pulse_clr(2'b01);
            send(TW[i], 1'b1);
            wait_idle();
            check_flag("threshold wake", TE[i], wake_thr_o);
            check_flag("burst request", !i[0], adc_req_o);
        end
        // pin two counted over two-period windows, converter ignored
        cfg_i = '0;
        cfg_i.src_sel = UDA_SRC_PC;
        cfg_i.gpio_sel = 2'h2;
        cfg_i.window_len = 10'h001;
        cfg_i.fifo_depth = 4'hF;
        restart();
        send(12'hABC, 1'b0);
        exp_q.push_back(20'h00001);
        exp_q.push_back(20'h00005);
        slow_period(1);
        slow_period(2);
        slow_period(3);
        slow_period(0);
        check_word("notes left", '0, 20'(exp_q.size()));
        close_out();
    end
endmodule : uda_top_bench
